// ---- exec_pkg.sv ----
package exec_pkg;

  // ----------------------------------------------------------------
  // Operations and addressing forms
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    OP_SUB_BORROW = 1'b0,
    OP_AND        = 1'b1
  } op_t;

  typedef enum logic [3:0] {
    F_A_IMM       = 4'h0,
    F_SADDR_IMM   = 4'h1,
    F_A_R         = 4'h2,
    F_R_A         = 4'h3,
    F_A_SADDR     = 4'h4,
    F_A_ABS       = 4'h5,
    F_A_HL        = 4'h6,
    F_A_HL_BYTE   = 4'h7,
    F_A_HL_B      = 4'h8,
    F_A_HL_C      = 4'h9,
    F_A_ES_ABS    = 4'hA,
    F_A_ES_HL     = 4'hB,
    F_A_ES_HL_BYT = 4'hC,
    F_A_ES_HL_B   = 4'hD,
    F_A_ES_HL_C   = 4'hE
  } form_t;

  typedef enum logic [1:0] {
    DST_ACC = 2'h0,
    DST_REG = 2'h1,
    DST_MEM = 2'h2
  } dest_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } state_t;

  // ----------------------------------------------------------------
  // Timing, lengths and address map
  // ----------------------------------------------------------------
  localparam logic [5:0] CLK_SHORT = 6'h01;
  localparam logic [5:0] CLK_SADDR_IMM = 6'h02;
  localparam logic [5:0] CLK_SEG = 6'h02;
  localparam logic [5:0] CLK_PROG = 6'h04;
  localparam logic [5:0] CLK_SEG_PROG = 6'h05;
  localparam logic [5:0] CLK_RAM_FETCH_ADD = 6'h03;
  localparam logic [5:0] CNT_RESET = 6'h00;
  localparam logic [2:0] LEN_1 = 3'h1;
  localparam logic [2:0] LEN_2 = 3'h2;
  localparam logic [2:0] LEN_3 = 3'h3;
  localparam logic [2:0] LEN_4 = 3'h4;
  localparam logic [19:0] SADDR_BASE = 20'hFFE20;
  localparam logic [3:0] DEFAULT_SEG = 4'hF;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [19:0] ADDR_RESET = 20'h00000;

endpackage

// ---- alu_if.sv ----
`timescale 1ns/1ps
interface alu_if;
  exec_pkg::op_t op;
  logic [7:0] a;
  logic [7:0] b;
  logic cyIn;
  logic acIn;
  logic [7:0] res;
  logic z;
  logic ac;
  logic cy;

  modport core (input op, a, b, cyIn, acIn, output res, z, ac, cy);
  modport user (output op, a, b, cyIn, acIn, input res, z, ac, cy);
endinterface

// ---- alu_core.sv ----
`timescale 1ns/1ps
module alu_core (
  // Operand and result bundle
  alu_if.core alu
);

  logic [8:0] diff;
  logic [4:0] lowDiff;

  // ----------------------------------------------------------------
  // Subtract with borrow and bitwise AND
  // ----------------------------------------------------------------
  always_comb begin
    diff = {1'b0, alu.a} - {1'b0, alu.b} - {8'h00, alu.cyIn};
    lowDiff = {1'b0, alu.a[3:0]} - {1'b0, alu.b[3:0]} - {4'h0, alu.cyIn};
    if (alu.op == exec_pkg::OP_AND) begin
      alu.res = alu.a & alu.b;
      alu.ac = alu.acIn;
      alu.cy = alu.cyIn;
    end else begin
      alu.res = diff[7:0];
      alu.ac = lowDiff[4];
      alu.cy = diff[8];
    end
    alu.z = (alu.res == 8'h00);
  end

endmodule // alu_core

// ---- sub_and_exec.sv ----
`timescale 1ns/1ps
module sub_and_exec (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Instruction request
  input wire logic start,
  input wire exec_pkg::op_t op,
  input wire exec_pkg::form_t form,
  input wire logic [7:0] immByte,
  input wire logic [7:0] offsetByte,
  input wire logic [15:0] addr16,
  input wire logic [7:0] saddr,
  // Timing context
  input wire logic dataInProgMem,
  input wire logic fetchFromRam,
  input wire logic nearFlashEnd,
  input wire logic [3:0] extWaits,
  // Processor state in
  input wire logic [7:0] accIn,
  input wire logic [7:0] regIn,
  input wire logic [7:0] idxB,
  input wire logic [7:0] idxC,
  input wire logic [15:0] pointerPair,
  input wire logic [3:0] segmentExtensionReg,
  input wire logic carryFlagIn,
  input wire logic auxCarryFlagIn,
  // Data memory port
  output logic memRd,
  output logic memWr,
  output logic [19:0] memAddr,
  output logic [7:0] memWdata,
  input wire logic [7:0] memRdata,
  input wire logic memRdy,
  // Result
  output logic busy,
  output logic done,
  output exec_pkg::dest_t dest,
  output logic [7:0] resultData,
  output logic zeroFlag,
  output logic auxCarryFlag,
  output logic carryFlag,
  output logic [2:0] instrLen,
  output logic [5:0] totalClocks
);

  typedef struct packed {
    exec_pkg::state_t st;
    exec_pkg::op_t op;
    exec_pkg::form_t form;
    logic [7:0] acc;
    logic [7:0] opA;
    logic [7:0] opB;
    logic needRd;
    logic got;
    logic cy;
    logic ac;
    logic [19:0] addr;
    logic [5:0] cnt;
    logic [5:0] total;
    logic done;
    logic wr;
    exec_pkg::dest_t dest;
    logic [7:0] res;
    logic z;
    logic acOut;
    logic cyOut;
    logic [2:0] len;
  } exec_state_t;

  exec_state_t s_q, s_d;
  alu_if alu ();

  alu_core u_alu (
    .alu(alu.core)
  );

  logic [5:0] baseClocks;
  logic [5:0] fullClocks;
  logic [2:0] lenOf;
  logic memForm;
  logic segForm;
  logic [15:0] offset;
  logic [19:0] effAddr;
  logic finish;

  // ----------------------------------------------------------------
  // Decode of the request
  // ----------------------------------------------------------------
  always_comb begin
    memForm = 1'b0;
    segForm = 1'b0;
    lenOf = exec_pkg::LEN_2;
    offset = pointerPair;
    unique case (form)
      exec_pkg::F_A_IMM, exec_pkg::F_A_R, exec_pkg::F_R_A, exec_pkg::F_A_SADDR,
      exec_pkg::F_A_HL_BYTE, exec_pkg::F_A_HL_B, exec_pkg::F_A_HL_C,
      exec_pkg::F_A_ES_HL: lenOf = exec_pkg::LEN_2;
      exec_pkg::F_SADDR_IMM, exec_pkg::F_A_ABS, exec_pkg::F_A_ES_HL_BYT,
      exec_pkg::F_A_ES_HL_B, exec_pkg::F_A_ES_HL_C: lenOf = exec_pkg::LEN_3;
      exec_pkg::F_A_HL: lenOf = exec_pkg::LEN_1;
      exec_pkg::F_A_ES_ABS: lenOf = exec_pkg::LEN_4;
      default: lenOf = exec_pkg::LEN_2;
    endcase
    unique case (form)
      exec_pkg::F_A_ABS, exec_pkg::F_A_ES_ABS: offset = addr16;
      exec_pkg::F_A_HL_BYTE, exec_pkg::F_A_ES_HL_BYT: offset = pointerPair + {8'h00, offsetByte};
      exec_pkg::F_A_HL_B, exec_pkg::F_A_ES_HL_B: offset = pointerPair + {8'h00, idxB};
      exec_pkg::F_A_HL_C, exec_pkg::F_A_ES_HL_C: offset = pointerPair + {8'h00, idxC};
      default: offset = pointerPair;
    endcase
    if (form >= exec_pkg::F_A_ABS) begin
      memForm = 1'b1;
    end
    if (form >= exec_pkg::F_A_ES_ABS) begin
      segForm = 1'b1;
    end
    // Segment extends the offset; others use the default bank
    effAddr = {segForm ? segmentExtensionReg : exec_pkg::DEFAULT_SEG, offset};
    if (form == exec_pkg::F_SADDR_IMM || form == exec_pkg::F_A_SADDR) begin
      effAddr = exec_pkg::SADDR_BASE + {12'h000, saddr};
    end
    // Clock count by data location
    if (form == exec_pkg::F_SADDR_IMM) begin
      baseClocks = exec_pkg::CLK_SADDR_IMM;
    end else if (segForm) begin
      baseClocks = dataInProgMem ? exec_pkg::CLK_SEG_PROG : exec_pkg::CLK_SEG;
    end else if (memForm && dataInProgMem) begin
      baseClocks = exec_pkg::CLK_PROG;
    end else begin
      baseClocks = exec_pkg::CLK_SHORT;
    end
    fullClocks = baseClocks;
    if (fetchFromRam) begin
      fullClocks = {baseClocks[4:0], 1'b0} + exec_pkg::CLK_RAM_FETCH_ADD;
    end
    if (nearFlashEnd) begin
      fullClocks = fullClocks + {2'h0, extWaits};
    end
  end

  // ----------------------------------------------------------------
  // Operand routing into the ALU
  // ----------------------------------------------------------------
  always_comb begin
    alu.op = s_q.op;
    alu.cyIn = s_q.cy;
    alu.acIn = s_q.ac;
    alu.a = s_q.opA;
    alu.b = s_q.opB;
    unique case (s_q.form)
      exec_pkg::F_A_IMM, exec_pkg::F_A_R, exec_pkg::F_R_A: begin
        alu.a = s_q.opA;
        alu.b = s_q.opB;
      end
      exec_pkg::F_SADDR_IMM: begin
        alu.a = memRdy ? memRdata : s_q.opA;
        alu.b = s_q.opB;
      end
      default: begin
        alu.a = s_q.acc;
        alu.b = memRdy ? memRdata : s_q.opB;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer: one count per processor clock
  // ----------------------------------------------------------------
  assign finish = (s_q.st == exec_pkg::ST_RUN) && (s_q.cnt >= s_q.total)
                  && (s_q.got || !s_q.needRd || memRdy);

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.wr = 1'b0;
    unique case (s_q.st)
      exec_pkg::ST_IDLE: begin
        if (start) begin
          s_d.st = exec_pkg::ST_RUN;
          s_d.op = op;
          s_d.form = form;
          s_d.acc = accIn;
          s_d.cy = carryFlagIn;
          s_d.ac = auxCarryFlagIn;
          s_d.addr = effAddr;
          s_d.cnt = 6'h01;
          s_d.total = fullClocks;
          s_d.len = lenOf;
          s_d.got = 1'b0;
          s_d.needRd = (form == exec_pkg::F_SADDR_IMM) || (form >= exec_pkg::F_A_SADDR);
          s_d.opA = (form == exec_pkg::F_R_A) ? regIn : accIn;
          s_d.opB = (form == exec_pkg::F_A_R) ? regIn
                    : (form == exec_pkg::F_R_A) ? accIn : immByte;
          s_d.dest = (form == exec_pkg::F_SADDR_IMM) ? exec_pkg::DST_MEM
                     : (form == exec_pkg::F_R_A) ? exec_pkg::DST_REG : exec_pkg::DST_ACC;
        end
      end
      exec_pkg::ST_RUN: begin
        if (s_q.cnt < s_q.total) begin
          s_d.cnt = s_q.cnt + 6'h01;
        end
        if (s_q.needRd && !s_q.got && memRdy) begin
          s_d.got = 1'b1;
          if (s_q.form == exec_pkg::F_SADDR_IMM) begin
            s_d.opA = memRdata;
          end else begin
            s_d.opB = memRdata;
          end
        end
        if (finish) begin
          s_d.st = exec_pkg::ST_IDLE;
          s_d.done = 1'b1;
          s_d.res = alu.res;
          s_d.z = alu.z;
          s_d.acOut = alu.ac;
          s_d.cyOut = alu.cy;
          s_d.wr = (s_q.dest == exec_pkg::DST_MEM);
        end
      end
      default: s_d.st = exec_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.cnt <= exec_pkg::CNT_RESET;
      s_q.addr <= exec_pkg::ADDR_RESET;
      s_q.res <= exec_pkg::BYTE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign busy = (s_q.st == exec_pkg::ST_RUN);
  assign memRd = busy && s_q.needRd && !s_q.got;
  assign memWr = s_q.wr;
  assign memAddr = s_q.addr;
  assign memWdata = s_q.res;
  assign done = s_q.done;
  assign dest = s_q.dest;
  assign resultData = s_q.res;
  assign zeroFlag = s_q.z;
  assign auxCarryFlag = s_q.acOut;
  assign carryFlag = s_q.cyOut;
  assign instrLen = s_q.len;
  assign totalClocks = s_q.total;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [5:0] elapsed;
  logic [8:0] expDiff;

  always_ff @(posedge clock) begin
    if (!rst_n || !busy) begin
      elapsed <= 6'h01;
    end else begin
      elapsed <= elapsed + 6'h01;
    end
  end

  always_comb begin
    expDiff = {1'b0, alu.a} - {1'b0, alu.b} - {8'h00, s_q.cy};
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_clock_count: assert property (finish |-> elapsed == s_q.total || (elapsed > s_q.total && memRdy))
    else $error("Instruction did not take its counted clocks");
  a_short_time: assert property (start && !busy && form == exec_pkg::F_A_IMM && !fetchFromRam
      && !nearFlashEnd |=> s_q.total == 6'h01)
    else $error("Short form count is not one clock");
  a_prog_time: assert property (start && !busy && form == exec_pkg::F_A_ES_HL && dataInProgMem
      && !fetchFromRam && !nearFlashEnd |=> s_q.total == 6'h05)
    else $error("Segmented program memory count is not five");
  a_ram_fetch: assert property (start && !busy && fetchFromRam && !nearFlashEnd
      |=> s_q.total == $past({baseClocks[4:0], 1'b0}) + 6'h03)
    else $error("RAM fetch count wrong");
  a_flash_waits: assert property (start && !busy && nearFlashEnd && !fetchFromRam
      && form == exec_pkg::F_SADDR_IMM |=> s_q.total == 6'h02 + {2'h0, $past(extWaits)})
    else $error("External waits not added");
  a_sub_result: assert property (finish && s_q.op == exec_pkg::OP_SUB_BORROW
      |=> resultData == $past(expDiff[7:0]) && carryFlag == $past(expDiff[8]))
    else $error("Subtract result or carry wrong");
  a_and_flags: assert property (finish && s_q.op == exec_pkg::OP_AND
      |=> carryFlag == $past(s_q.cy) && auxCarryFlag == $past(s_q.ac) && zeroFlag == (resultData == 8'h00))
    else $error("AND changed carry flags");
  a_saddr_write: assert property (done && dest == exec_pkg::DST_MEM
      |-> memWr && instrLen == 3'h3 && totalClocks >= 6'h02)
    else $error("Short address write-back wrong");
  a_seg_index: assert property (start && !busy && form == exec_pkg::F_A_ES_HL_B
      |=> memAddr == {$past(segmentExtensionReg), $past(pointerPair) + {8'h00, $past(idxB)}})
    else $error("Segmented indexed address wrong");
  a_aux_borrow: assert property (finish && s_q.op == exec_pkg::OP_SUB_BORROW
      |=> auxCarryFlag == ($past(alu.a[3:0]) < ({1'b0, $past(alu.b[3:0])} + {4'h0, $past(s_q.cy)})))
    else $error("Aux borrow wrong");

  c_sub_saddr: cover property (done && dest == exec_pkg::DST_MEM && s_q.op == exec_pkg::OP_SUB_BORROW);
  c_and_seg: cover property (done && s_q.form == exec_pkg::F_A_ES_HL_C && s_q.op == exec_pkg::OP_AND);
  c_ram_fetch: cover property (start && !busy && fetchFromRam && dataInProgMem);
  c_waits: cover property (start && !busy && nearFlashEnd && extWaits != 4'h0);

endmodule // sub_and_exec

// ---- data_mem_model.sv ----
`timescale 1ns/1ps
// ----
// Data memory answering the read port
// ----
module data_mem_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Memory port
  input wire logic memRd,
  input wire logic [19:0] memAddr,
  output logic [7:0] memRdata,
  output logic memRdy,
  // Answer delay in cycles
  input wire logic [1:0] lag
);
  logic [1:0] cnt;
  logic sent;
  always_ff @(posedge clock) begin
    memRdy <= 1'b0;
    // Stale data toggles outside the answer cycle
    memRdata <= ~memRdata;
    if (!rst_n) begin
      memRdata <= 8'h00;
    end
    if (!rst_n || !memRd) begin
      cnt <= 2'h0;
      sent <= 1'b0;
    end else if (!sent) begin
      if (cnt == lag) begin
        memRdy <= 1'b1;
        memRdata <= memAddr[7:0] ^ memAddr[15:8] ^ 8'h3C;
        sent <= 1'b1;
      end else begin
        cnt <= cnt + 2'h1;
      end
    end
  end
endmodule // data_mem_model

// ---- sub_and_exec_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin testsRun++; if ((g) !== (e)) begin badCount++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module sub_and_exec_tb_top;
  logic clock, rst_n, start, dataInProgMem, fetchFromRam, nearFlashEnd, carryFlagIn;
  logic auxCarryFlagIn, memRd, memWr, memRdy, busy, done, zeroFlag, auxCarryFlag, carryFlag;
  logic [7:0] immByte, offsetByte, saddr, accIn, regIn, idxB, idxC, memRdata, memWdata;
  logic [7:0] resultData;
  logic [15:0] addr16, pointerPair;
  logic [3:0] extWaits, segmentExtensionReg;
  logic [19:0] memAddr;
  logic [2:0] instrLen;
  logic [5:0] totalClocks;
  logic [1:0] lag;
  exec_pkg::op_t op;
  exec_pkg::form_t form;
  exec_pkg::dest_t dest;
  int badCount, testsRun;
  logic [2:0] lens [0:14] = '{3'h2, 3'h3, 3'h2, 3'h2, 3'h2, 3'h3, 3'h1, 3'h2, 3'h2, 3'h2,
    3'h4, 3'h2, 3'h3, 3'h3, 3'h3};

  sub_and_exec dut (.*);
  data_mem_model mem (.*);

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic endSim();
    $display("checks=%0d mismatches=%0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----
  // One instruction, issued in the current cycle
  // ----
  task automatic run(input logic o, input logic [3:0] f, input logic [7:0] x0, im, rg,
      input logic c, h, pm, rm, nr, input logic [3:0] w, input logic [1:0] lg, input logic jk);
    logic [19:0] ea;
    logic [15:0] hl, ofs;
    logic [7:0] m, x, y, r;
    logic [8:0] d;
    logic [4:0] dl;
    logic [5:0] base, tot;
    logic [1:0] dt;
    logic rd;
    int n, nx;
    hl = {x0, im};
    case (f)
      4'h5, 4'hA: ofs = {im, x0};
      4'h6, 4'hB: ofs = hl;
      4'h7, 4'hC: ofs = hl + 16'h0007;
      4'h8, 4'hD: ofs = hl + {8'h00, im};
      4'h9, 4'hE: ofs = hl + {8'h00, x0};
      default: ofs = 16'h0000;
    endcase
    rd = (f == 4'h1 || f >= 4'h4);
    ea = (f == 4'h1 || f == 4'h4) ? 20'hFFE20 + {12'h000, im ^ 8'h11}
      : {(f >= 4'hA) ? x0[3:0] : 4'hF, ofs};
    m = ea[7:0] ^ ea[15:8] ^ 8'h3C;
    x = (f == 4'h1) ? m : (f == 4'h3) ? rg : x0;
    y = (f <= 4'h1) ? im : (f == 4'h2) ? rg : (f == 4'h3) ? x0 : m;
    d = {1'b0, x} - {1'b0, y} - {8'h00, c};
    dl = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, c};
    r = o ? x & y : d[7:0];
    dt = (f == 4'h1) ? 2'h2 : (f == 4'h3) ? 2'h1 : 2'h0;
    base = (f >= 4'hA) ? (pm ? 6'h05 : 6'h02) : (f >= 4'h5 && pm) ? 6'h04
      : (f == 4'h1) ? 6'h02 : 6'h01;
    tot = (rm ? 6'h02 * base + 6'h03 : base) + (nr ? {2'h0, w} : 6'h00);
    nx = (rd && tot < 2 + lg) ? 2 + lg : tot;
    op <= exec_pkg::op_t'(o);
    form <= exec_pkg::form_t'(f);
    immByte <= im;
    offsetByte <= 8'h07;
    addr16 <= {im, x0};
    saddr <= im ^ 8'h11;
    accIn <= x0;
    regIn <= rg;
    idxB <= im;
    idxC <= x0;
    pointerPair <= hl;
    segmentExtensionReg <= x0[3:0];
    carryFlagIn <= c;
    auxCarryFlagIn <= h;
    dataInProgMem <= pm;
    fetchFromRam <= rm;
    nearFlashEnd <= nr;
    extWaits <= w;
    lag <= lg;
    start <= 1'b1;
    @(posedge clock);
    start <= jk;
    if (jk) begin
      op <= exec_pkg::op_t'(~o);
      accIn <= ~x0;
    end
    for (n = 1; n <= 60; n++) begin
      @(posedge clock);
      #1;
      if (n == 1 && jk) begin
        start <= 1'b0;
      end
      if (n == 1) begin
        `CHK(memRd, rd)
      end
      if (done === 1'b1) begin
        break;
      end
    end
    if (n > 60) begin
      badCount++;
      endSim();
    end
    `CHK(n, nx)
    `CHK(totalClocks, tot)
    `CHK(resultData, r)
    `CHK(zeroFlag, r == 8'h00)
    `CHK(auxCarryFlag, o ? h : dl[4])
    `CHK(carryFlag, o ? c : d[8])
    `CHK(dest, exec_pkg::dest_t'(dt))
    `CHK(instrLen, lens[f])
    `CHK(memWr, dt == 2'h2)
    `CHK(busy, 1'b0)
    if (dt == 2'h2) begin
      `CHK(memWdata, r)
    end
    if (rd) begin
      `CHK(memAddr, ea)
    end
  endtask

  // ----
  // Scenarios
  // ----
  task automatic allForms();
    for (int i = 0; i < 30; i++) begin
      run(i >= 15, 4'(i % 15), 8'h93 ^ 8'(i * 13), 8'h5E + 8'(i), 8'hC7, i[0], i[1],
        1'b0, 1'b0, 1'b0, 4'h0, 2'h0, i == 20);
    end
  endtask

  task automatic progMem();
    for (int f = 5; f < 15; f++) begin
      run(f[0], 4'(f), 8'hA0 + 8'(f), 8'h0F, 8'h00, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0,
        2'h2, 1'b0);
    end
  endtask

  task automatic fetchTiming();
    run(1'b0, 4'h0, 8'h44, 8'h12, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 4'h0, 2'h0, 1'b0);
    run(1'b0, 4'hD, 8'h2B, 8'h61, 8'h00, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'hF, 2'h1, 1'b0);
    run(1'b1, 4'h1, 8'h77, 8'h3E, 8'h00, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 4'h3, 2'h0, 1'b0);
    run(1'b0, 4'h4, 8'h08, 8'h90, 8'h00, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 4'h0, 2'h1, 1'b0);
  endtask

  task automatic flagEdges();
    run(1'b0, 4'h0, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 2'h0, 1'b0);
    run(1'b0, 4'h0, 8'h10, 8'h0F, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 2'h0, 1'b0);
    run(1'b0, 4'h0, 8'h05, 8'h04, 8'h00, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 2'h0, 1'b0);
    run(1'b1, 4'h0, 8'h0F, 8'hF0, 8'h00, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 2'h0, 1'b0);
    run(1'b0, 4'h3, 8'h01, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 2'h0, 1'b0);
  endtask

  initial begin
    rst_n = 1'b0;
    start = 1'b0;
    op = exec_pkg::OP_SUB_BORROW;
    form = exec_pkg::F_A_IMM;
    {immByte, offsetByte, saddr, accIn, regIn, idxB, idxC} = 56'h0;
    {addr16, pointerPair, extWaits, segmentExtensionReg, lag} = 42'h0;
    {dataInProgMem, fetchFromRam, nearFlashEnd, carryFlagIn, auxCarryFlagIn} = 5'h0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    #1;
    `CHK({done, busy, memWr, resultData, totalClocks}, 17'h0)
    allForms();
    progMem();
    fetchTiming();
    flagEdges();
    endSim();
  end
endmodule // sub_and_exec_tb_top
